//--- rtl/lecb_defs.svh
// Offsets, field positions, reset values and sizes of the line error counter bank
`ifndef LECB_DEFS_SVH
`define LECB_DEFS_SVH

// ----------------------------------------------------------------------------
// Pages of the microport
// ----------------------------------------------------------------------------
`define LECB_PAGE_COUNTERS   8'h04
`define LECB_PAGE_ONE_SEC    8'h09

// ----------------------------------------------------------------------------
// Register offsets within a page
// ----------------------------------------------------------------------------
`define LECB_ADDR_PRBS_ERR   5'h10
`define LECB_ADDR_PRBS_MF    5'h11
`define LECB_ADDR_EBIT_A     5'h13
`define LECB_ADDR_EBIT_B     5'h14
`define LECB_ADDR_JITTER     5'h15
`define LECB_ADDR_OVF_LATCH  5'h16
`define LECB_ADDR_FRAME_LOSS 5'h17
`define LECB_ADDR_ALIGN_BIT  5'h18
`define LECB_ADDR_ALIGN_WORD 5'h1A
`define LECB_ADDR_BPV_LOW    5'h1C
`define LECB_ADDR_BPV_HIGH   5'h1D
`define LECB_ADDR_CRC_LOW    5'h1E
`define LECB_ADDR_CRC_HIGH   5'h1F

// ----------------------------------------------------------------------------
// Counter indices, widths and reset values
// ----------------------------------------------------------------------------
`define LECB_NUM_CNT         9
`define LECB_IDX_PRBS_ERR    4'd0
`define LECB_IDX_PRBS_MF     4'd1
`define LECB_IDX_EBIT        4'd2
`define LECB_IDX_JITTER      4'd3
`define LECB_IDX_FRAME_LOSS  4'd4
`define LECB_IDX_ALIGN_BIT   4'd5
`define LECB_IDX_ALIGN_WORD  4'd6
`define LECB_IDX_BPV         4'd7
`define LECB_IDX_CRC         4'd8
`define LECB_WIDTH_BYTE      5'd8
`define LECB_WIDTH_TEN       5'd10
`define LECB_WIDTH_BPV       5'd16
`define LECB_CNT_RESET       16'h0000
`define LECB_LATCH_RESET     8'h00

`endif

//--- rtl/lecb_pkg.sv
// Types shared by the line error counter bank
package lecb_pkg;

   // Receive error events, one-cycle pulses except the jitter levels
   typedef struct packed {
      logic       prbs_err;
      logic       crc4_mframe;
      logic       ebit_err;
      logic       jb_near_underflow;
      logic       jb_near_overflow;
      logic       frame_loss;
      logic       fas_strobe;
      logic [2:0] fas_bit_errs;
      logic       bpv_err;
      logic       crc4_err;
   } lecb_events_type;

   // Microport request
   typedef struct packed {
      logic       cs;
      logic       wr;
      logic       rd;
      logic [7:0] page;
      logic [4:0] addr;
      logic [7:0] wdata;
   } lecb_req_type;

   // Decoded counter location
   typedef struct packed {
      logic       hit;
      logic [3:0] idx;
      logic       hi;
   } lecb_loc_type;

endpackage

//--- rtl/lecb_counter_bank.sv
// Maintenance error counter bank of a 2.048 Mbit/s trunk framer
`timescale 1ns/1ps
`include "lecb_defs.svh"

module lecb_counter_bank
   import lecb_pkg::*;
#(
   parameter int NUM_CNT = `LECB_NUM_CNT
) (
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   input  wire lecb_req_type         up_req,
   output logic [7:0]                up_rdata,
   input  wire lecb_events_type      events,
   input  wire logic                 counter_clear,
   input  wire logic                 one_sec_tick,
   input  wire logic [NUM_CNT-1:0]   event_mask,
   input  wire logic [NUM_CNT-1:0]   overflow_mask,
   output logic [NUM_CNT-1:0]        event_irq,
   output logic [NUM_CNT-1:0]        overflow_irq,
   output logic                      prbs_overflow_irq,
   output logic                      ebit_event_irq,
   output logic                      ebit_overflow_irq,
   output logic                      alignment_bit_event_irq,
   output logic                      alignment_bit_overflow_irq,
   output logic                      errored_word_event_irq,
   output logic                      errored_word_overflow_irq,
   output logic                      bipolar_violation_event_irq,
   output logic                      bipolar_violation_overflow_irq,
   output logic                      jb_speed_up,
   output logic                      jb_slow_down,
   output logic [7:0]                counter_overflow_latch
);

   // -------------------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------------------
   function automatic logic [4:0] cnt_width(input logic [3:0] idx);
      unique case (idx)
         `LECB_IDX_EBIT, `LECB_IDX_CRC: cnt_width = `LECB_WIDTH_TEN;
         `LECB_IDX_BPV:                 cnt_width = `LECB_WIDTH_BPV;
         default:                       cnt_width = `LECB_WIDTH_BYTE;
      endcase
   endfunction

   function automatic logic [15:0] cnt_mask(input logic [3:0] idx);
      logic [16:0] full;
      full     = (17'h00001 << cnt_width(idx)) - 17'h00001;
      cnt_mask = full[15:0];
   endfunction

   function automatic lecb_loc_type decode(input logic [4:0] addr);
      lecb_loc_type loc;
      loc = '{hit: 1'b1, idx: 4'h0, hi: 1'b0};
      unique case (addr)
         `LECB_ADDR_PRBS_ERR:   loc.idx = `LECB_IDX_PRBS_ERR;
         `LECB_ADDR_PRBS_MF:    loc.idx = `LECB_IDX_PRBS_MF;
         `LECB_ADDR_EBIT_A:     loc.idx = `LECB_IDX_EBIT;
         `LECB_ADDR_EBIT_B:     begin
            loc.idx = `LECB_IDX_EBIT;
            loc.hi  = 1'b1;
         end
         `LECB_ADDR_JITTER:     loc.idx = `LECB_IDX_JITTER;
         `LECB_ADDR_FRAME_LOSS: loc.idx = `LECB_IDX_FRAME_LOSS;
         `LECB_ADDR_ALIGN_BIT:  loc.idx = `LECB_IDX_ALIGN_BIT;
         `LECB_ADDR_ALIGN_WORD: loc.idx = `LECB_IDX_ALIGN_WORD;
         `LECB_ADDR_BPV_LOW:    loc.idx = `LECB_IDX_BPV;
         `LECB_ADDR_BPV_HIGH:   begin
            loc.idx = `LECB_IDX_BPV;
            loc.hi  = 1'b1;
         end
         `LECB_ADDR_CRC_LOW:    loc.idx = `LECB_IDX_CRC;
         `LECB_ADDR_CRC_HIGH:   begin
            loc.idx = `LECB_IDX_CRC;
            loc.hi  = 1'b1;
         end
         default:               loc.hit = 1'b0;
      endcase
      return loc;
   endfunction

   // Overflow latch bit of a counter; the time counter has none
   function automatic logic [2:0] latch_bit(input logic [3:0] idx);
      logic [3:0] b;
      b         = (idx > `LECB_IDX_PRBS_MF) ? idx - 4'd1 : idx;
      latch_bit = b[2:0];
   endfunction

   // The multiframe time counter is the only one without a latch bit
   function automatic logic has_latch(input logic [3:0] idx);
      has_latch = (idx != `LECB_IDX_PRBS_MF);
   endfunction

   // Counters copied into the one-second page
   function automatic logic snapshotted(input logic [3:0] idx);
      unique case (idx)
         `LECB_IDX_EBIT, `LECB_IDX_ALIGN_WORD,
         `LECB_IDX_BPV, `LECB_IDX_CRC: snapshotted = 1'b1;
         default:                       snapshotted = 1'b0;
      endcase
   endfunction

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   logic [15:0]        cnt_q [NUM_CNT];
   logic [15:0]        cnt_d [NUM_CNT];
   logic [NUM_CNT-1:0] ovf;
   logic [NUM_CNT-1:0] tog;
   logic [2:0]         inc   [NUM_CNT];
   logic [15:0]        snap_q [NUM_CNT];
   logic               jb_near_q;
   logic [7:0]         latch_q;
   lecb_loc_type       loc;
   logic               wr_cnt;
   logic               rd_latch;
   logic               wr_any;
   logic               rd_any;
   logic               cnt_page;
   logic               snap_page;
   logic [7:0]         rd_byte;

   assign loc       = decode(up_req.addr);
   assign wr_any    = up_req.cs && up_req.wr;
   assign rd_any    = up_req.cs && up_req.rd;
   assign cnt_page  = (up_req.page == `LECB_PAGE_COUNTERS);
   assign snap_page = (up_req.page == `LECB_PAGE_ONE_SEC);
   assign wr_cnt    = wr_any && loc.hit && cnt_page;
   assign rd_latch  = rd_any && cnt_page && (up_req.addr == `LECB_ADDR_OVF_LATCH);

   // -------------------------------------------------------------------------
   // Increment sources
   // -------------------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_CNT; i++) begin
         inc[i] = 3'd0;
      end
      inc[`LECB_IDX_PRBS_ERR]   = {2'b00, events.prbs_err};
      inc[`LECB_IDX_PRBS_MF]    = {2'b00, events.crc4_mframe};
      inc[`LECB_IDX_EBIT]       = {2'b00, events.ebit_err};
      inc[`LECB_IDX_JITTER]     = {2'b00, (events.jb_near_underflow
                                          || events.jb_near_overflow) && !jb_near_q};
      inc[`LECB_IDX_FRAME_LOSS] = {2'b00, events.frame_loss};
      inc[`LECB_IDX_ALIGN_BIT]  = events.fas_strobe ? events.fas_bit_errs : 3'd0;
      inc[`LECB_IDX_ALIGN_WORD] = {2'b00, events.fas_strobe
                                          && (events.fas_bit_errs != 3'd0)};
      inc[`LECB_IDX_BPV]        = {2'b00, events.bpv_err};
      inc[`LECB_IDX_CRC]        = {2'b00, events.crc4_err};
   end

   // -------------------------------------------------------------------------
   // Counter next values
   // -------------------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_CNT; i++) begin
         logic [16:0] sum;
         logic [15:0] wval;
         logic [3:0]  ii;
         ii   = 4'(i);
         sum  = {1'b0, cnt_q[i]} + {14'h0000, inc[i]};
         wval = cnt_q[i];
         // Wrap modulo the counter range and carry on; overflow marks a whole range counted
         ovf[i]   = (inc[i] != 3'd0) && ((sum[15:0] & ~cnt_mask(ii)) != 16'h0000
                                         || sum[16]);
         tog[i]   = inc[i][0];
         cnt_d[i] = sum[15:0] & cnt_mask(ii);
         // A host write beats a count in the same cycle; the clear beats both
         if (wr_cnt && loc.idx == ii) begin
            if (loc.hi) begin
               wval[15:8] = up_req.wdata;
            end else begin
               wval[7:0] = up_req.wdata;
            end
            cnt_d[i] = wval & cnt_mask(ii);
            ovf[i]   = 1'b0;
            tog[i]   = 1'b0;
         end
         if (wr_cnt && loc.idx == `LECB_IDX_PRBS_ERR && ii == `LECB_IDX_PRBS_MF) begin
            cnt_d[i] = `LECB_CNT_RESET;
            ovf[i]   = 1'b0;
            tog[i]   = 1'b0;
         end
         if (counter_clear) begin
            cnt_d[i] = `LECB_CNT_RESET;
            ovf[i]   = 1'b0;
            tog[i]   = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_CNT; i++) begin
            cnt_q[i] <= `LECB_CNT_RESET;
         end
      end else begin
         for (int i = 0; i < NUM_CNT; i++) begin
            cnt_q[i] <= cnt_d[i];
         end
      end
   end

   // -------------------------------------------------------------------------
   // Jitter buffer limit and read clock steering
   // -------------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         jb_near_q <= 1'b0;
      end else begin
         jb_near_q <= events.jb_near_underflow || events.jb_near_overflow;
      end
   end

   // Reading faster near overflow and slower near underflow keeps the pointers apart
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         jb_speed_up  <= 1'b0;
         jb_slow_down <= 1'b0;
      end else begin
         jb_speed_up  <= events.jb_near_overflow;
         jb_slow_down <= events.jb_near_underflow;
      end
   end

   // -------------------------------------------------------------------------
   // One-second snapshot
   // -------------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_CNT; i++) begin
            snap_q[i] <= `LECB_CNT_RESET;
         end
      end else if (one_sec_tick) begin
         for (int i = 0; i < NUM_CNT; i++) begin
            if (snapshotted(4'(i))) begin
               snap_q[i] <= cnt_q[i];
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Overflow latch, set wins over the clearing read
   // -------------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         latch_q <= `LECB_LATCH_RESET;
      end else begin
         logic [7:0] set;
         set = 8'h00;
         for (int i = 0; i < NUM_CNT; i++) begin
            if (ovf[i] && has_latch(4'(i))) begin
               set[latch_bit(4'(i))] = 1'b1;
            end
         end
         latch_q <= (rd_latch ? 8'h00 : latch_q) | set;
      end
   end

   assign counter_overflow_latch = latch_q;

   // -------------------------------------------------------------------------
   // Interrupt pulses
   // -------------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         event_irq <= '0;
      end else begin
         for (int i = 0; i < NUM_CNT; i++) begin
            event_irq[i] <= tog[i] && event_mask[i];
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         overflow_irq <= '0;
      end else begin
         for (int i = 0; i < NUM_CNT; i++) begin
            overflow_irq[i] <= ovf[i] && overflow_mask[i];
         end
      end
   end

   assign prbs_overflow_irq              = overflow_irq[`LECB_IDX_PRBS_ERR];
   assign ebit_event_irq                 = event_irq[`LECB_IDX_EBIT];
   assign ebit_overflow_irq              = overflow_irq[`LECB_IDX_EBIT];
   assign alignment_bit_event_irq        = event_irq[`LECB_IDX_ALIGN_BIT];
   assign alignment_bit_overflow_irq     = overflow_irq[`LECB_IDX_ALIGN_BIT];
   assign errored_word_event_irq         = event_irq[`LECB_IDX_ALIGN_WORD];
   assign errored_word_overflow_irq      = overflow_irq[`LECB_IDX_ALIGN_WORD];
   assign bipolar_violation_event_irq    = event_irq[`LECB_IDX_BPV];
   assign bipolar_violation_overflow_irq = overflow_irq[`LECB_IDX_BPV];

   // -------------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------------
   // A latch read returns the bits that the same edge clears
   always_comb begin
      logic [15:0] word;
      word = 16'h0000;
      if (cnt_page && loc.hit) begin
         word = cnt_q[loc.idx];
      end else if (snap_page && loc.hit) begin
         word = snap_q[loc.idx];
      end
      rd_byte = loc.hi ? word[15:8] : word[7:0];
      if (rd_latch) begin
         rd_byte = latch_q;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         up_rdata <= 8'h00;
      end else if (rd_any) begin
         up_rdata <= rd_byte;
      end
   end

endmodule // lecb_counter_bank

//--- sim/lecb_counter_bank_sva.sv
// Concurrent checks on the ports of the line error counter bank
`timescale 1ns/1ps
`include "lecb_defs.svh"

module lecb_counter_bank_sva
   import lecb_pkg::*;
#(
   parameter int NUM_CNT = `LECB_NUM_CNT
) (
   input wire logic                 clock,
   input wire logic                 rst_n,
   input wire lecb_req_type         up_req,
   input wire logic [7:0]           up_rdata,
   input wire lecb_events_type      events,
   input wire logic                 counter_clear,
   input wire logic [NUM_CNT-1:0]   event_mask,
   input wire logic [NUM_CNT-1:0]   overflow_mask,
   input wire logic [NUM_CNT-1:0]   event_irq,
   input wire logic [NUM_CNT-1:0]   overflow_irq,
   input wire logic                 prbs_overflow_irq,
   input wire logic                 ebit_event_irq,
   input wire logic                 alignment_bit_event_irq,
   input wire logic                 errored_word_event_irq,
   input wire logic                 bipolar_violation_event_irq,
   input wire logic                 jb_speed_up,
   input wire logic                 jb_slow_down,
   input wire logic [7:0]           counter_overflow_latch
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   logic quiet;
   logic latch_rd;
   assign quiet    = !up_req.cs && !counter_clear;
   assign latch_rd = up_req.cs && up_req.rd && up_req.page == `LECB_PAGE_COUNTERS
                     && up_req.addr == `LECB_ADDR_OVF_LATCH;

   sequence s_latch_read;
      latch_rd;
   endsequence
   sequence s_wrap_hit;
      events.jb_near_overflow && !$past(events.jb_near_overflow);
   endsequence

   property p_mask;
      (event_irq | overflow_irq) != '0 |->
         ((event_irq & ~$past(event_mask)) | (overflow_irq & ~$past(overflow_mask))) == '0;
   endproperty
   a_mask: assert property (p_mask) else $error("irq on masked counter");
   property p_ebit_evt;
      events.ebit_err && event_mask[2] && quiet |=> ebit_event_irq;
   endproperty
   a_ebit_evt: assert property (p_ebit_evt) else $error("ebit event irq missing");
   property p_bpv_evt;
      events.bpv_err && event_mask[7] && quiet |=> bipolar_violation_event_irq;
   endproperty
   a_bpv_evt: assert property (p_bpv_evt) else $error("bpv event irq missing");
   property p_word_evt;
      events.fas_strobe && events.fas_bit_errs != 3'h0 && event_mask[6] && quiet
         |=> errored_word_event_irq;
   endproperty
   a_word_evt: assert property (p_word_evt) else $error("errored word irq missing");
   property p_bit_evt;
      alignment_bit_event_irq |-> $past(events.fas_strobe && events.fas_bit_errs[0]);
   endproperty
   a_bit_evt: assert property (p_bit_evt) else $error("align bit irq without odd add");
   property p_clear;
      counter_clear |=> event_irq == '0 && overflow_irq == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("irq while counters cleared");
   property p_latch_hold;
      !$past(latch_rd) |->
         (counter_overflow_latch & $past(counter_overflow_latch)) == $past(counter_overflow_latch);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch bit fell unread");
   property p_latch_set;
      (overflow_irq[0] -> counter_overflow_latch[0]) && (overflow_irq[7] -> counter_overflow_latch[6]);
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("overflow not latched");
   property p_rd_data;
      s_latch_read |=> up_rdata == $past(counter_overflow_latch);
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("latch read value wrong");
   property p_prbs_ovf;
      prbs_overflow_irq |-> $past(events.prbs_err) && overflow_irq[0];
   endproperty
   a_prbs_ovf: assert property (p_prbs_ovf) else $error("prbs overflow irq uncaused");
   property p_jb;
      s_wrap_hit |=> jb_speed_up && !jb_slow_down;
   endproperty
   a_jb: assert property (p_jb) else $error("read clock not adjusted");
   property p_jb_slow;
      events.jb_near_underflow && !events.jb_near_overflow |=> jb_slow_down && !jb_speed_up;
   endproperty
   a_jb_slow: assert property (p_jb_slow) else $error("read clock not slowed");
endmodule // lecb_counter_bank_sva

bind lecb_counter_bank lecb_counter_bank_sva #(.NUM_CNT(NUM_CNT)) u_sva (
   .clock, .rst_n, .up_req, .up_rdata, .events, .counter_clear, .event_mask, .overflow_mask,
   .event_irq, .overflow_irq, .prbs_overflow_irq, .ebit_event_irq, .alignment_bit_event_irq,
   .errored_word_event_irq, .bipolar_violation_event_irq, .jb_speed_up, .jb_slow_down,
   .counter_overflow_latch
);

//--- sim/lecb_host_model.sv
// Host microprocessor model driving the counter bank microport
`timescale 1ns/1ps

module lecb_host_model
   import lecb_pkg::*;
(
   input  wire logic     clock,
   input  wire logic [7:0] up_rdata,
   output lecb_req_type  up_req
);
   initial up_req = '0;

   // One access per call; strobes drop and data inverts after the taking edge
   task automatic access(logic w, logic [7:0] p, logic [4:0] a, logic [7:0] d);
      @(posedge clock);
      up_req <= '{cs:1'b1, wr:w, rd:!w, page:p, addr:a, wdata:d};
      @(posedge clock);
      up_req <= '{cs:1'b0, wr:1'b0, rd:1'b0, page:p, addr:a, wdata:~d};
   endtask
   task automatic wr(logic [7:0] p, logic [4:0] a, logic [7:0] d);
      access(1'b1, p, a, d);
   endtask
   task automatic rd(logic [7:0] p, logic [4:0] a, output logic [7:0] d);
      access(1'b0, p, a, 8'h00);
      #1 d = up_rdata;
   endtask
   task automatic wr_bpv(logic [15:0] v);
      wr(8'h04, 5'h1C, v[7:0]);
      wr(8'h04, 5'h1D, v[15:8]);
   endtask
endmodule // lecb_host_model

//--- sim/line_error_counter_bank_bench.sv
// Self-checking bench of the line error counter bank
`timescale 1ns/1ps

module line_error_counter_bank_bench;
   import lecb_pkg::*;
   logic            clock;
   logic            rst_n;
   lecb_req_type    up_req;
   logic [7:0]      up_rdata;
   lecb_events_type ev;
   logic            clr;
   logic            tick;
   logic [8:0]      emask;
   logic [8:0]      omask;
   int              bad_count;
   int              num_checks;
   logic [4:0]      rst_addrs [13] = '{5'h10, 5'h11, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17,
                                      5'h18, 5'h1A, 5'h1C, 5'h1D, 5'h1E, 5'h1F};

   lecb_host_model host (.clock(clock), .up_rdata(up_rdata), .up_req(up_req));
   lecb_counter_bank dut (
      .clock(clock), .rst_n(rst_n), .up_req(up_req), .up_rdata(up_rdata), .events(ev),
      .counter_clear(clr), .one_sec_tick(tick), .event_mask(emask), .overflow_mask(omask),
      .event_irq(), .overflow_irq(), .prbs_overflow_irq(), .ebit_event_irq(),
      .ebit_overflow_irq(), .alignment_bit_event_irq(), .alignment_bit_overflow_irq(),
      .errored_word_event_irq(), .errored_word_overflow_irq(),
      .bipolar_violation_event_irq(), .bipolar_violation_overflow_irq(),
      .jb_speed_up(), .jb_slow_down(), .counter_overflow_latch()
   );

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic check(logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: read %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rc(logic [7:0] p, logic [4:0] a, logic [7:0] e);
      logic [7:0] v;
      host.rd(p, a, v);
      check(v, e);
   endtask
   task automatic pulse(lecb_events_type e, int n);
      repeat (n) begin
         @(posedge clock);
         ev <= e;
         @(posedge clock);
         ev <= '0;
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (6000) @(posedge clock);
      bad_count++;
      tally_and_finish;
   end

   initial begin
      rst_n = 1'b0; ev = '0; clr = 1'b0; tick = 1'b0; emask = 9'h1FF; omask = 9'h1FF;
      bad_count = 0; num_checks = 0;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      foreach (rst_addrs[i]) rc(8'h04, rst_addrs[i], 8'h00);
      rc(8'h04, 5'h12, 8'h00);
      host.wr(8'h04, 5'h11, 8'h33);
      host.wr(8'h04, 5'h10, 8'h05);
      rc(8'h04, 5'h10, 8'h05);
      rc(8'h04, 5'h11, 8'h00);
      host.wr(8'h04, 5'h11, 8'hFE);
      pulse('{crc4_mframe:1'b1, default:'0}, 3);
      rc(8'h04, 5'h11, 8'h01);
      host.wr(8'h04, 5'h10, 8'hFF);
      pulse('{prbs_err:1'b1, default:'0}, 1);
      rc(8'h04, 5'h10, 8'h00);
      rc(8'h04, 5'h16, 8'h01);
      rc(8'h04, 5'h16, 8'h00);
      host.wr(8'h04, 5'h13, 8'hFF);
      host.wr(8'h04, 5'h14, 8'h03);
      pulse('{ebit_err:1'b1, default:'0}, 2);
      rc(8'h04, 5'h13, 8'h01);
      rc(8'h04, 5'h14, 8'h00);
      rc(8'h04, 5'h16, 8'h02);
      @(posedge clock) ev <= '{jb_near_overflow:1'b1, default:'0};
      repeat (3) @(posedge clock);
      ev <= '0;
      @(posedge clock) ev <= '{jb_near_underflow:1'b1, default:'0};
      repeat (2) @(posedge clock);
      ev <= '0;
      rc(8'h04, 5'h15, 8'h02);
      pulse('{frame_loss:1'b1, default:'0}, 1);
      rc(8'h04, 5'h17, 8'h01);
      host.wr(8'h04, 5'h18, 8'hFE);
      pulse('{fas_strobe:1'b1, fas_bit_errs:3'h3, default:'0}, 1);
      rc(8'h04, 5'h18, 8'h01);
      pulse('{fas_strobe:1'b1, default:'0}, 1);
      rc(8'h04, 5'h1A, 8'h01);
      host.wr(8'h04, 5'h1A, 8'hFF);
      pulse('{fas_strobe:1'b1, fas_bit_errs:3'h7, default:'0}, 1);
      rc(8'h04, 5'h18, 8'h08);
      rc(8'h04, 5'h1A, 8'h00);
      rc(8'h04, 5'h16, 8'h30);
      host.wr_bpv(16'h1234);
      pulse('{bpv_err:1'b1, default:'0}, 1);
      rc(8'h04, 5'h1C, 8'h35);
      pulse('{crc4_err:1'b1, default:'0}, 2);
      rc(8'h04, 5'h1E, 8'h02);
      @(posedge clock) tick <= 1'b1;
      @(posedge clock) tick <= 1'b0;
      rc(8'h09, 5'h1C, 8'h35);
      rc(8'h09, 5'h1D, 8'h12);
      rc(8'h09, 5'h1E, 8'h02);
      rc(8'h09, 5'h13, 8'h01);
      host.wr_bpv(16'hFFFF);
      pulse('{bpv_err:1'b1, default:'0}, 1);
      rc(8'h04, 5'h1C, 8'h00);
      rc(8'h04, 5'h1D, 8'h00);
      rc(8'h04, 5'h16, 8'h40);
      @(posedge clock) clr <= 1'b1;
      pulse('{prbs_err:1'b1, ebit_err:1'b1, bpv_err:1'b1, default:'0}, 2);
      rc(8'h04, 5'h18, 8'h00);
      rc(8'h04, 5'h17, 8'h00);
      rc(8'h04, 5'h13, 8'h00);
      rc(8'h04, 5'h10, 8'h00);
      @(posedge clock) clr <= 1'b0;
      emask <= 9'h0FB;
      omask <= 9'h1FE;
      host.wr(8'h04, 5'h10, 8'hFF);
      pulse('{prbs_err:1'b1, ebit_err:1'b1, bpv_err:1'b1, default:'0}, 1);
      rc(8'h04, 5'h10, 8'h00);
      rc(8'h04, 5'h16, 8'h01);
      host.wr(8'h04, 5'h10, 8'h07);
      @(posedge clock) rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rc(8'h04, 5'h10, 8'h00);
      tally_and_finish;
   end
endmodule // line_error_counter_bank_bench
